// ---- logic/core_instr_exec_subset.v ----
// Execution unit for a subset of an 8-bit core's instructions
// Summary of operation
// - A watchdog clear forces the watchdog counter to zero.
// - A watchdog clear also zeroes the watchdog prescaler in the same cycle.
// - A watchdog clear sets timeout and power-down flags, nothing else.
// - A call first pushes the program counter plus one onto the stack.
// - A call loads its 11-bit literal into program counter bits 10 to 0.
// - A call loads counter bits 12 and 11 from latch-high bits 4 and 3.
// - A call takes two instruction cycles and alters no status flag.
// - A complement inverts the file register and updates the zero flag.
// - Destination bit zero sends results to working, one to the file.
// - A clear-file writes zero to the addressed file and sets zero flag.
// - A clear-working writes zero to working and sets the zero flag.
// - A decrement subtracts one, routes by destination, updates zero.
// - A decrement-and-skip subtracts one, routes, leaves flags alone.
// - A zero decrement-and-skip result discards the next instruction.
//
// Our own choices: the plain strobed port and the register offsets.
`include "core_exec_consts.vh"

module core_instr_exec_subset #(
   parameter PRE_W = 7,                 // Watchdog prescaler width
   parameter WDT_W = 8,                 // Watchdog counter width
   parameter SP_W  = 3                  // Stack pointer width
) (
   input  wire        clk_sys,          // Instruction clock
   input  wire        rst_b,            // Asynchronous reset, active low
   input  wire        instr_valid,      // Instruction offered
   input  wire [2:0]  instr_op,         // Operation select
   input  wire [6:0]  instr_file,       // File register address
   input  wire        instr_dest,       // 0 working, 1 file
   input  wire [10:0] instr_literal,    // Call literal
   output wire        instr_ready,      // Instruction taken when high
   output reg         skip_taken,       // Pulse: next instruction dropped
   output reg         watchdog_expired, // Pulse: watchdog overflow
   output reg  [12:0] program_counter,  // Current program counter
   output wire [12:0] stack_top,        // Top of return stack
   input  wire [2:0]  reg_addr,         // Register address
   input  wire [7:0]  reg_wdata,        // Register write data
   input  wire        reg_wr,           // Write strobe
   input  wire        reg_rd,           // Read strobe
   output reg  [7:0]  reg_rdata         // Read data, cycle after strobe
);

   // One-hot sequencer states; each two-cycle form owns a state
   localparam ST_RUN   = 3'b001;
   localparam ST_CALL2 = 3'b010;
   localparam ST_SKIP2 = 3'b100;
   localparam DEPTH    = 1 << SP_W;

   // Architectural state; file and stack memories carry no reset
   reg  [2:0]       state;
   reg  [2:0]       next_state;
   reg  [7:0]       working;
   reg  [4:0]       pc_latch_high;
   reg              zero_flag;
   reg              timeout_flag;
   reg              power_down_flag;
   reg  [WDT_W-1:0] watchdog_counter;
   reg  [PRE_W-1:0] watchdog_prescale;
   reg  [6:0]       file_index;
   reg  [SP_W-1:0]  stack_ptr;
   reg  [12:0]      stack_mem [0:DEPTH-1];
   reg  [7:0]       file_mem  [0:127];

   // Decode and datapath nets of the offered instruction
   wire             take;
   wire [7:0]       file_val;
   reg  [7:0]       result;
   reg              to_file;
   reg              to_working;
   reg              zero_upd;
   reg  [12:0]      next_pc;

   // Only the two-cycle forms hold off the next instruction
   assign instr_ready = (state == ST_RUN);
   assign take        = instr_valid & instr_ready;
   assign file_val    = file_mem[instr_file];
   assign stack_top   = stack_mem[stack_ptr - 1'b1];

   // Counter padded to a byte for the read port; a wider counter
   // shows only its low eight bits
   wire [7:0]       watchdog_byte;
   genvar           g;
   generate
      for (g = 0; g < 8; g = g + 1) begin : g_watchdog_byte
         if (g < WDT_W) begin : g_bit
            assign watchdog_byte[g] = watchdog_counter[g];
         end else begin : g_pad
            assign watchdog_byte[g] = 1'b0;
         end
      end
   endgenerate

   // True for operations whose result follows the destination bit
   function routed;
      input [2:0] op;
      begin
         routed = (op == `OP_COMPLEMENT_FILE) ||
                  (op == `OP_DECREMENT_FILE)  ||
                  (op == `OP_DECREMENT_SKIP);
      end
   endfunction

   // True for operations that update the zero flag from the result
   function sets_zero;
      input [2:0] op;
      begin
         sets_zero = (op == `OP_COMPLEMENT_FILE) ||
                     (op == `OP_DECREMENT_FILE)  ||
                     (op == `OP_CLEAR_FILE)      ||
                     (op == `OP_CLEAR_WORKING);
      end
   endfunction

   // Result datapath and write routing
   always @* begin
      result     = `RST_BYTE;
      to_file    = 1'b0;
      to_working = 1'b0;
      zero_upd   = 1'b0;
      if (take) begin
         case (instr_op)
            `OP_COMPLEMENT_FILE: result = ~file_val;
            `OP_DECREMENT_FILE:  result = file_val - 8'h01;
            `OP_DECREMENT_SKIP:  result = file_val - 8'h01;
            default:             result = `RST_BYTE;
         endcase
         if (routed(instr_op)) begin
            to_file    = instr_dest;
            to_working = ~instr_dest;
         end
         if (instr_op == `OP_CLEAR_FILE)
            to_file = 1'b1;
         if (instr_op == `OP_CLEAR_WORKING)
            to_working = 1'b1;
         zero_upd = sets_zero(instr_op);
      end
   end

   // Sequencer and program counter next values
   always @* begin
      next_state = state;
      next_pc    = program_counter;
      case (state)
         ST_RUN: begin
            if (take) begin
               if (instr_op == `OP_CALL) begin
                  next_pc = {pc_latch_high[`LATCH_PAGE_HI:`LATCH_PAGE_LO],
                             instr_literal[`LIT_HI:0]};
                  next_state = ST_CALL2;
               end else if (instr_op == `OP_DECREMENT_SKIP &&
                            result == `RST_BYTE) begin
                  next_pc = program_counter + 13'h0001;
                  next_state = ST_SKIP2;
               end else begin
                  next_pc = program_counter + 13'h0001;
               end
            end
         end
         ST_CALL2: next_state = ST_RUN;
         ST_SKIP2: begin
            // discarded slot runs as a no-operation
            next_pc    = program_counter + 13'h0001;
            next_state = ST_RUN;
         end
         default: next_state = ST_RUN;
      endcase
   end

   // State, program counter and skip pulse
   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         state           <= ST_RUN;
         program_counter <= `RST_PC;
         skip_taken      <= 1'b0;
      end else begin
         state           <= next_state;
         program_counter <= next_pc;
         skip_taken      <= (next_state == ST_SKIP2);
      end
   end

   // Return stack: pointer wraps, so an overflow overwrites the oldest
   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         stack_ptr <= {SP_W{1'b0}};
      end else if (take && instr_op == `OP_CALL) begin
         stack_ptr <= stack_ptr + 1'b1;
      end
   end

   always @(posedge clk_sys) begin
      if (take && instr_op == `OP_CALL)
         stack_mem[stack_ptr] <= program_counter + 13'h0001;
   end

   // File registers; the instruction write wins over a software write
   // Software reaches a file only through the index register
   always @(posedge clk_sys) begin
      if (to_file)
         file_mem[instr_file] <= result;
      else if (reg_wr && reg_addr == `REG_FILE_DATA)
         file_mem[file_index] <= reg_wdata;
   end

   // Working register, latch-high and file index
   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         working       <= `RST_BYTE;
         pc_latch_high <= `RST_LATCH;
         file_index    <= 7'h00;
      end else begin
         if (to_working)
            working <= result;
         else if (reg_wr && reg_addr == `REG_WORKING)
            working <= reg_wdata;
         if (reg_wr && reg_addr == `REG_PC_LATCH_HIGH)
            pc_latch_high <= reg_wdata[4:0];
         if (reg_wr && reg_addr == `REG_FILE_INDEX)
            file_index <= reg_wdata[6:0];
      end
   end

   // Zero flag; an instruction update takes priority over software
   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         zero_flag <= 1'b0;
      end else if (zero_upd) begin
         // clear forms yield zero and so set the flag
         zero_flag <= (result == `RST_BYTE);
      end else if (reg_wr && reg_addr == `REG_STATUS) begin
         zero_flag <= reg_wdata[`BIT_ZERO];
      end
   end

   // Watchdog: prescaler carries into the counter; clear beats overflow
   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         watchdog_prescale <= {PRE_W{1'b0}};
         watchdog_counter  <= {WDT_W{1'b0}};
         timeout_flag      <= `RST_FLAG_SET;
         power_down_flag   <= `RST_FLAG_SET;
         watchdog_expired  <= 1'b0;
      end else if (take && instr_op == `OP_WATCHDOG_CLEAR) begin
         watchdog_counter  <= {WDT_W{1'b0}};
         watchdog_prescale <= {PRE_W{1'b0}};
         timeout_flag      <= 1'b1;
         power_down_flag   <= 1'b1;
         watchdog_expired  <= 1'b0;
      end else begin
         watchdog_prescale <= watchdog_prescale + 1'b1;
         watchdog_expired  <= 1'b0;
         if (&watchdog_prescale) begin
            watchdog_counter <= watchdog_counter + 1'b1;
            if (&watchdog_counter) begin
               // Flag is active low: zero marks a watchdog overflow
               timeout_flag     <= 1'b0;
               watchdog_expired <= 1'b1;
            end
         end
      end
   end

   // Read data stand only in the cycle after the strobe
   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         reg_rdata <= `RST_BYTE;
      end else if (reg_rd) begin
         case (reg_addr)
            `REG_STATUS:        reg_rdata <= {3'h0, timeout_flag,
                                              power_down_flag, zero_flag,
                                              2'h0};
            `REG_WORKING:       reg_rdata <= working;
            `REG_PC_LATCH_HIGH: reg_rdata <= {3'h0, pc_latch_high};
            `REG_PC_LOW:        reg_rdata <= program_counter[7:0];
            `REG_PC_HIGH:       reg_rdata <= {3'h0, program_counter[12:8]};
            `REG_WATCHDOG:      reg_rdata <= watchdog_byte;
            `REG_FILE_INDEX:    reg_rdata <= {1'b0, file_index};
            `REG_FILE_DATA:     reg_rdata <= file_mem[file_index];
            default:            reg_rdata <= `RST_BYTE;
         endcase
      end else begin
         reg_rdata <= `RST_BYTE;
      end
   end

endmodule

// ---- pkg/core_exec_consts.vh ----
// Constants for the instruction execution subset: opcodes, offsets, fields
`ifndef CORE_EXEC_CONSTS_VH
`define CORE_EXEC_CONSTS_VH

// Operation select codes on the instruction port
`define OP_NONE            3'h0
`define OP_WATCHDOG_CLEAR  3'h1
`define OP_CALL            3'h2
`define OP_COMPLEMENT_FILE 3'h3
`define OP_CLEAR_FILE      3'h4
`define OP_CLEAR_WORKING   3'h5
`define OP_DECREMENT_FILE  3'h6
`define OP_DECREMENT_SKIP  3'h7

// Register offsets on the software port
`define REG_STATUS         3'h0
`define REG_WORKING        3'h1
`define REG_PC_LATCH_HIGH  3'h2
`define REG_PC_LOW         3'h3
`define REG_PC_HIGH        3'h4
`define REG_WATCHDOG       3'h5
`define REG_FILE_INDEX     3'h6
`define REG_FILE_DATA      3'h7

// Status field positions
`define BIT_ZERO           2
`define BIT_POWER_DOWN     3
`define BIT_TIMEOUT        4

// Call target fields
`define LIT_HI             10
`define LATCH_PAGE_HI      4
`define LATCH_PAGE_LO      3

// Reset values
`define RST_BYTE           8'h00
`define RST_PC             13'h0000
`define RST_LATCH          5'h00
`define RST_FLAG_SET       1'b1

// Cycle counts of the two-cycle forms
`define CALL_CYCLES        2
`define SKIP_CYCLES        2

`endif

// ---- testbench/core_exec_properties.sv ----
// Port checker for the instruction execution subset
`include "core_exec_consts.vh"
module core_exec_properties (
   input logic        clk_sys,         // Instruction clock
   input logic        rst_b,           // Reset, active low
   input logic        instr_valid,     // Instruction offered
   input logic [2:0]  instr_op,        // Operation select
   input logic [10:0] instr_literal,   // Call literal
   input logic        instr_ready,     // Instruction taken when high
   input logic        skip_taken,      // Discarded cycle marker
   input logic [12:0] program_counter, // Program counter
   input logic [12:0] stack_top        // Top of return stack
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   // Taken requests, split by their cycle count
   wire take = instr_valid && instr_ready;
   wire call = take && instr_op == `OP_CALL;
   wire skp  = take && instr_op == `OP_DECREMENT_SKIP;
   wire one  = take && !call && !skp;
   call_literal_a:
      assert property (call |=> program_counter[10:0] == $past(instr_literal))
      else $error("call target low bits wrong");
   call_push_a:
      assert property (call |=> stack_top == $past(program_counter) + 13'h1)
      else $error("return address wrong");
   call_stall_a:
      assert property (call |=> !instr_ready ##1 instr_ready)
      else $error("call not two cycles");
   call_hold_a:
      assert property (call |=> ##1 $stable(program_counter))
      else $error("counter moved in second call cycle");
   single_cycle_a:
      assert property (one |=> instr_ready &&
                       program_counter == $past(program_counter) + 13'h1)
      else $error("one-cycle op misbehaved");
   skip_stall_a:
      assert property (skip_taken |-> !instr_ready ##1 (instr_ready &&
         !skip_taken && program_counter == $past(program_counter) + 13'h1))
      else $error("discarded cycle wrong");
   skip_cause_a:
      assert property ($rose(skip_taken) |-> $past(skp))
      else $error("skip without decrement-and-skip");
   skip_pc_a:
      assert property (skp |=>
                       program_counter == $past(program_counter) + 13'h1)
      else $error("counter not advanced on skip op");
endmodule
bind core_instr_exec_subset core_exec_properties u_props (.clk_sys, .rst_b,
   .instr_valid, .instr_op, .instr_literal, .instr_ready, .skip_taken,
   .program_counter, .stack_top);

// ---- testbench/tb_top.sv ----
// Self-checking bench for the instruction execution subset
`include "core_exec_consts.vh"
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [6:0] F = 7'h7F; // Top file address as boundary
   typedef struct packed {
      logic [2:0] op;
      logic       dest;
      logic [7:0] init;
      logic [7:0] res;
      logic       z;
   } row_t;
   logic        clk_sys, rst_b, instr_valid, instr_dest, reg_wr, reg_rd;
   logic [2:0]  instr_op, reg_addr;
   logic [6:0]  instr_file;
   logic [10:0] instr_literal;
   logic [7:0]  reg_wdata, rd_val;
   logic [12:0] old_pc;
   wire         instr_ready, skip_taken, watchdog_expired;
   wire  [12:0] program_counter, stack_top;
   wire  [7:0]  reg_rdata;
   int          errors, samples_checked;
   row_t        rows [6];
   // Short watchdog counts so overflow happens early in the run
   core_instr_exec_subset #(.PRE_W(2), .WDT_W(2)) u_dut (.clk_sys, .rst_b,
      .instr_valid, .instr_op, .instr_file, .instr_dest, .instr_literal,
      .instr_ready, .skip_taken, .watchdog_expired, .program_counter,
      .stack_top, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
   task automatic chk(input logic [12:0] seen, input logic [12:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         errors++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk_sys);
      reg_wr    <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [2:0] a);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk_sys);
      reg_rd   <= 1'b0;
      #1 rd_val = reg_rdata;
   endtask
   // Old counter is caught before the take edge, not raced against it
   task automatic ex(input logic [2:0] op, input logic d,
                     input logic [10:0] k);
      @(posedge clk_sys);
      instr_valid   <= 1'b1;
      instr_op      <= op;
      instr_dest    <= d;
      instr_literal <= k;
      #1 old_pc = program_counter;
      @(posedge clk_sys);
      instr_valid   <= 1'b0;
      #1;
   endtask
   task automatic complete_run;
      if (errors == 0 && samples_checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end
   // Watchdog far beyond the fewer than two hundred cycles the tests need
   initial begin
      #(5000 * 25);
      errors++;
      complete_run();
   end
   initial begin
      {rst_b, instr_valid, instr_dest, reg_wr, reg_rd} = 5'h00;
      {instr_op, reg_addr, instr_literal, reg_wdata} = 25'h0000000;
      instr_file = F;
      rows = '{'{`OP_COMPLEMENT_FILE, 1'b1, 8'hFF, 8'h00, 1'b1},
               '{`OP_COMPLEMENT_FILE, 1'b0, 8'h0F, 8'hF0, 1'b0},
               '{`OP_DECREMENT_FILE, 1'b1, 8'h01, 8'h00, 1'b1},
               '{`OP_DECREMENT_FILE, 1'b0, 8'h00, 8'hFF, 1'b0},
               '{`OP_CLEAR_FILE, 1'b1, 8'h5A, 8'h00, 1'b1},
               '{`OP_CLEAR_WORKING, 1'b0, 8'h5A, 8'h00, 1'b1}};
      repeat (2) @(posedge clk_sys);
      rst_b <= 1'b1;
      rd(`REG_STATUS);
      chk(rd_val[4:2], 3'b110);
      chk(program_counter, 13'h0000);
      // Zero flag preset to the opposite so an update is seen
      for (int i = 0; i < 6; i++) begin
         wr(`REG_FILE_INDEX, {1'b0, F});
         wr(`REG_FILE_DATA, rows[i].init);
         wr(`REG_WORKING, 8'hAA);
         wr(`REG_STATUS, {5'h00, ~rows[i].z, 2'h0});
         ex(rows[i].op, rows[i].dest, 11'h000);
         rd(`REG_FILE_DATA);
         chk(rd_val, rows[i].dest ? rows[i].res : rows[i].init);
         rd(`REG_WORKING);
         chk(rd_val, rows[i].dest ? 8'hAA : rows[i].res);
         rd(`REG_STATUS);
         chk(rd_val[`BIT_ZERO], rows[i].z);
      end
      // Calls at the top literal, then with the return address wrapping
      wr(`REG_PC_LATCH_HIGH, 8'h18);
      ex(`OP_CALL, 1'b0, 11'h7FF);
      chk(stack_top, old_pc + 13'h0001);
      chk(program_counter, 13'h1FFF);
      chk(instr_ready, 1'b0);
      wr(`REG_PC_LATCH_HIGH, 8'h0F);
      ex(`OP_CALL, 1'b0, 11'h2AA);
      chk(stack_top, 13'h0000);
      chk(program_counter, 13'h0AAA);
      // Decrement-and-skip with zero and nonzero results
      wr(`REG_FILE_DATA, 8'h01);
      wr(`REG_STATUS, 8'h00);
      ex(`OP_DECREMENT_SKIP, 1'b1, 11'h000);
      chk(skip_taken, 1'b1);
      rd(`REG_FILE_DATA);
      chk(rd_val, 8'h00);
      rd(`REG_STATUS);
      chk(rd_val[`BIT_ZERO], 1'b0);
      ex(`OP_DECREMENT_SKIP, 1'b0, 11'h000);
      chk(skip_taken, 1'b0);
      rd(`REG_WORKING);
      chk(rd_val, 8'hFF);
      // Another file address: the clear must hit that file alone
      wr(`REG_FILE_DATA, 8'h3C);
      wr(`REG_FILE_INDEX, 8'h00);
      wr(`REG_FILE_DATA, 8'h5A);
      instr_file <= 7'h00;
      ex(`OP_CLEAR_FILE, 1'b1, 11'h000);
      rd(`REG_FILE_DATA);
      chk(rd_val, 8'h00);
      wr(`REG_FILE_INDEX, {1'b0, F});
      rd(`REG_FILE_DATA);
      chk(rd_val, 8'h3C);
      // No-operation code only advances the counter
      ex(`OP_NONE, 1'b0, 11'h000);
      chk(program_counter, old_pc + 13'h0001);
      // Watchdog has long since overflowed, so the timeout flag is low
      rd(`REG_STATUS);
      chk(rd_val[`BIT_TIMEOUT], 1'b0);
      wr(`REG_STATUS, 8'h04);
      ex(`OP_WATCHDOG_CLEAR, 1'b0, 11'h000);
      rd(`REG_WATCHDOG);
      chk(rd_val, 8'h00);
      rd(`REG_STATUS);
      chk(rd_val[4:2], 3'b111);
      // Cleared counter and prescaler overflow 16 cycles after the clear
      repeat (11) @(posedge clk_sys);
      #1 chk(watchdog_expired, 1'b0);
      @(posedge clk_sys);
      #1 chk(watchdog_expired, 1'b1);
      // Mid-run reset returns counter, sequencer and flags to rest
      @(posedge clk_sys);
      rst_b <= 1'b0;
      repeat (2) @(posedge clk_sys);
      #1 chk(program_counter, 13'h0000);
      chk(instr_ready, 1'b1);
      chk(skip_taken, 1'b0);
      @(posedge clk_sys);
      rst_b <= 1'b1;
      rd(`REG_STATUS);
      chk(rd_val[4:2], 3'b110);
      complete_run();
   end
endmodule
